// [logic/mpa_pkg.sv]
// Constants shared by the motor PWM and sampler logic.
// Assumes one 50 MHz peripheral clock and a 32-bit word register port.
package mpa_pkg;
  // ****************
  // Timing
  // ****************
  localparam int  CLK_NS       = 20;
  localparam real CARRIER_US   = 50.0;
  localparam int  TICK_US      = 500;
  // Triangle carrier: up then down, so a half period of counts
  localparam int  CARRIER_TOP  = int'(CARRIER_US * 1000.0 / (2.0 * CLK_NS));
  localparam int  TICK_CYC     = TICK_US * 1000 / CLK_NS;
  localparam int  CNT_W        = 12;
  localparam int  RES_W        = 12;
  localparam int  DEAD_W       = 8;
  localparam int  NCH          = 5;
  localparam logic [3:0] SCAN_END_PRIO = 4'h5;
  // ****************
  // Register offsets (byte addresses)
  // ****************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_DEAD   = 8'h04;
  localparam logic [7:0] A_CMP_U  = 8'h08;
  localparam logic [7:0] A_CMP_V  = 8'h0C;
  localparam logic [7:0] A_CMP_W  = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_RES0   = 8'h18;
  localparam int  CTRL_RUN     = 0;
  localparam int  CTRL_TRIPCLR = 1;
  localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CMP_RST  = 12'h000;
  // Sampler channel order within one scan
  typedef enum logic [2:0] {
    MPA_CH_U_CUR = 3'h0,
    MPA_CH_V_CUR = 3'h1,
    MPA_CH_W_CUR = 3'h2,
    MPA_CH_VDC   = 3'h3,
    MPA_CH_SPEED = 3'h4
  } mpa_ch_e;
  typedef enum logic [1:0] {
    MPA_S_IDLE  = 2'h0,
    MPA_S_START = 2'h1,
    MPA_S_WAIT  = 2'h2
  } mpa_scan_e;
endpackage : mpa_pkg

// [logic/mpa_carrier_if.sv]
// Carrier bundle from the timer core to each phase output stage.
// Assumes all users sit on the same clock.
`timescale 1ns/1ps
interface mpa_carrier_if;
  logic [mpa_pkg::CNT_W-1:0]  cnt;
  logic [mpa_pkg::DEAD_W-1:0] dead;
  logic                       run;
  logic                       ce;
  modport src (output cnt, output dead, output run, output ce);
  modport dst (input cnt, input dead, input run, input ce);
endinterface : mpa_carrier_if

// [logic/mpa_phase.sv]
// One complementary PWM phase with dead time.
// Assumes the carrier bundle is driven on the same clock.
`timescale 1ns/1ps
module mpa_phase (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  mpa_carrier_if.dst                     car,
  input  wire logic [mpa_pkg::CNT_W-1:0] cmp,
  output logic                           hi_q,
  output logic                           lo_q
);
  logic                        raw;
  logic                        raw_q;
  logic [mpa_pkg::DEAD_W-1:0]  dt_q;

  assign raw = car.cnt < cmp;

  // ****************
  // Dead-time insertion
  // ****************
  // A change of the raw level turns both switches off first, so the leg never shoots through
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      raw_q <= 1'b0;
      dt_q  <= '0;
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
    end else if (car.ce) begin
      raw_q <= raw;
      if (!car.run) begin
        hi_q <= 1'b0;
        lo_q <= 1'b0;
        dt_q <= car.dead;
      end else if (raw != raw_q) begin
        hi_q <= 1'b0;
        lo_q <= 1'b0;
        dt_q <= car.dead;
      end else if (dt_q != '0) begin
        dt_q <= dt_q - 1'b1;
      end else begin
        hi_q <= raw_q;
        lo_q <= !raw_q;
      end
    end
  end

  // ****************
  // Checks
  // ****************
  property p_no_overlap;
    @(posedge clk) disable iff (!resetn) !(hi_q && lo_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches of a leg on");

  property p_dead_gap;
    @(posedge clk) disable iff (!resetn || !car.ce)
      ($fell(hi_q) && car.dead != '0) |=> !lo_q;
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("low side on without dead time");
endmodule : mpa_phase

// [logic/mpa_top.sv]
// Three-phase PWM with valley-synchronised current sampling and overcurrent cut-off.
// Assumes a converter front end on the same clock that answers each start with one done pulse.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Sampler converts three phase currents, bus voltage, speed command as one hardware-started scan.
// - Each scan starts at the carrier valley, the counter underflow.
// - Only the channel 1 timer underflow triggers; second group and double trigger off.
// - Every channel is converted with 12-bit resolution.
// - Scan completion raises the scan-end interrupt at priority 5.
// - Window compare A, B and second-group scan-end interrupts never fire.
// - Tick timer raises an interval event every 500 microseconds.
// - Channels 1 to 3 drive complementary pairs with dead time.
// - Low level on the overcurrent input puts all PWM pins in high impedance.
// - Timer counts triangle-wave symmetric, underflow at trough, period 50.0 microseconds.
module mpa_top #(
  parameter int TICK_CYC    = mpa_pkg::TICK_CYC,
  parameter int CARRIER_TOP = mpa_pkg::CARRIER_TOP
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      clk_en,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  output logic      [5:0]                pwm_out,
  output logic      [5:0]                pwm_oe,
  input  wire logic                      overcurrent_trip_input_n,
  output logic                           adc_start,
  output logic      [2:0]                adc_ch,
  input  wire logic [mpa_pkg::RES_W-1:0] adc_data,
  input  wire logic                      adc_done,
  output logic                           scan_end_irq,
  output logic      [3:0]                scan_end_prio,
  output logic                           scan_end_b_irq,
  output logic                           wcmp_a_irq,
  output logic                           wcmp_b_irq,
  output logic                           tick_event
);
  // ****************
  // Declarations
  // ****************
  logic                         run_q;
  logic [mpa_pkg::DEAD_W-1:0]   dead_q;
  logic [mpa_pkg::CNT_W-1:0]    cmp_q [3];
  logic [mpa_pkg::CNT_W-1:0]    cnt_q;
  logic                         down_q;
  logic                         unf;
  logic                         trip_s1_q;
  logic                         trip_s2_q;
  logic                         tripped_q;
  logic [mpa_pkg::RES_W-1:0]    res_q [mpa_pkg::NCH];
  mpa_pkg::mpa_scan_e           st_q;
  logic [2:0]                   ch_q;
  logic [$clog2(TICK_CYC)-1:0]  tick_cnt_q;
  logic [5:0]                   pwm_int;
  logic                         res_sel;
  logic [2:0]                   res_idx;
  mpa_carrier_if                car ();

  assign res_sel = (reg_addr >= mpa_pkg::A_RES0) && (reg_addr < mpa_pkg::A_RES0 + 8'h14)
                   && (reg_addr[1:0] == 2'h0);
  assign res_idx = 3'((reg_addr - mpa_pkg::A_RES0) >> 2);

  // ****************
  // Control registers
  // ****************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_q    <= 1'b0;
      dead_q   <= mpa_pkg::DEAD_RST;
      cmp_q[0] <= mpa_pkg::CMP_RST;
      cmp_q[1] <= mpa_pkg::CMP_RST;
      cmp_q[2] <= mpa_pkg::CMP_RST;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        mpa_pkg::A_CTRL:  run_q    <= reg_wdata[mpa_pkg::CTRL_RUN];
        mpa_pkg::A_DEAD:  dead_q   <= reg_wdata[mpa_pkg::DEAD_W-1:0];
        mpa_pkg::A_CMP_U: cmp_q[0] <= reg_wdata[mpa_pkg::CNT_W-1:0];
        mpa_pkg::A_CMP_V: cmp_q[1] <= reg_wdata[mpa_pkg::CNT_W-1:0];
        mpa_pkg::A_CMP_W: cmp_q[2] <= reg_wdata[mpa_pkg::CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // ****************
  // Triangle carrier
  // ****************
  // Count 0 up to the top and back, so the trough at zero is the valley of the waveform
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= '0;
      down_q <= 1'b0;
    end else if (clk_en) begin
      if (!run_q) begin
        cnt_q  <= '0;
        down_q <= 1'b0;
      end else if (!down_q) begin
        if (cnt_q == mpa_pkg::CNT_W'(CARRIER_TOP - 1)) down_q <= 1'b1;
        cnt_q <= cnt_q + 1'b1;
      end else begin
        if (cnt_q == mpa_pkg::CNT_W'(1)) down_q <= 1'b0;
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Underflow pulse of channel 1 at the trough
  assign unf = run_q && down_q && (cnt_q == mpa_pkg::CNT_W'(1));

  assign car.cnt  = cnt_q;
  assign car.dead = dead_q;
  assign car.run  = run_q;
  assign car.ce   = clk_en;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    mpa_phase u_phase (
      .clk    (clk),
      .resetn (resetn),
      .car    (car.dst),
      .cmp    (cmp_q[p]),
      .hi_q   (pwm_int[2*p]),
      .lo_q   (pwm_int[2*p+1])
    );
  end

  // ****************
  // Output disable
  // ****************
  // Latched so a brief glitch of the trip still keeps the bridge off until software clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trip_s1_q <= 1'b1;
      trip_s2_q <= 1'b1;
      tripped_q <= 1'b0;
    end else if (clk_en) begin
      trip_s1_q <= overcurrent_trip_input_n;
      trip_s2_q <= trip_s1_q;
      if (!trip_s2_q) begin
        tripped_q <= 1'b1;
      end else if (reg_wr && reg_addr == mpa_pkg::A_CTRL && reg_wdata[mpa_pkg::CTRL_TRIPCLR]) begin
        tripped_q <= 1'b0;
      end
    end
  end

  assign pwm_out = pwm_int;
  assign pwm_oe  = tripped_q ? 6'h00 : 6'h3F;

  // ****************
  // Sampler scan
  // ****************
  // Triggers arriving mid-scan are dropped; a full scan must fit inside one carrier period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q         <= mpa_pkg::MPA_S_IDLE;
      ch_q         <= 3'h0;
      adc_start    <= 1'b0;
      scan_end_irq <= 1'b0;
    end else if (clk_en) begin
      adc_start    <= 1'b0;
      scan_end_irq <= 1'b0;
      unique case (st_q)
        mpa_pkg::MPA_S_IDLE: begin
          if (unf) begin
            st_q <= mpa_pkg::MPA_S_START;
            ch_q <= mpa_pkg::MPA_CH_U_CUR;
          end
        end
        mpa_pkg::MPA_S_START: begin
          adc_start <= 1'b1;
          st_q      <= mpa_pkg::MPA_S_WAIT;
        end
        mpa_pkg::MPA_S_WAIT: begin
          if (adc_done) begin
            if (ch_q == mpa_pkg::MPA_CH_SPEED) begin
              st_q         <= mpa_pkg::MPA_S_IDLE;
              scan_end_irq <= 1'b1;
            end else begin
              ch_q <= ch_q + 1'b1;
              st_q <= mpa_pkg::MPA_S_START;
            end
          end
        end
        default: st_q <= mpa_pkg::MPA_S_IDLE;
      endcase
    end
  end

  assign adc_ch         = ch_q;
  assign scan_end_prio  = mpa_pkg::SCAN_END_PRIO;
  assign scan_end_b_irq = 1'b0;
  assign wcmp_a_irq     = 1'b0;
  assign wcmp_b_irq     = 1'b0;

  // Results: a new conversion wins over a read-clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < mpa_pkg::NCH; i++) res_q[i] <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < mpa_pkg::NCH; i++) begin
        if (st_q == mpa_pkg::MPA_S_WAIT && adc_done && ch_q == 3'(i)) begin
          res_q[i] <= adc_data;
        end else if (reg_rd && res_sel && res_idx == 3'(i)) begin
          res_q[i] <= '0;
        end
      end
    end
  end

  // ****************
  // Tick timer
  // ****************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= '0;
      tick_event <= 1'b0;
    end else if (clk_en) begin
      tick_event <= 1'b0;
      if (tick_cnt_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
        tick_cnt_q <= '0;
        tick_event <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // ****************
  // Register read
  // ****************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (res_sel) begin
          reg_rdata <= {20'h00000, res_q[res_idx]};
        end else begin
          unique case (reg_addr)
            mpa_pkg::A_CTRL:   reg_rdata <= {31'h00000000, run_q};
            mpa_pkg::A_DEAD:   reg_rdata <= {24'h000000, dead_q};
            mpa_pkg::A_CMP_U:  reg_rdata <= {20'h00000, cmp_q[0]};
            mpa_pkg::A_CMP_V:  reg_rdata <= {20'h00000, cmp_q[1]};
            mpa_pkg::A_CMP_W:  reg_rdata <= {20'h00000, cmp_q[2]};
            mpa_pkg::A_STATUS: reg_rdata <= {29'h00000000, down_q, st_q != mpa_pkg::MPA_S_IDLE, tripped_q};
            default: ;
          endcase
        end
      end
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !clk_en);

  property p_trig_at_valley;
    (st_q == mpa_pkg::MPA_S_IDLE && unf) |=> ##1 (adc_start && adc_ch == 3'h0);
  endproperty
  a_trig_at_valley: assert property (p_trig_at_valley) else $error("scan not started at valley");

  property p_start_cause;
    $rose(st_q != mpa_pkg::MPA_S_IDLE) |-> $past(unf);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("scan started without underflow");

  property p_scan_end;
    (st_q == mpa_pkg::MPA_S_WAIT && adc_done && ch_q == 3'h4) |=> scan_end_irq && st_q == mpa_pkg::MPA_S_IDLE;
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan end missing after last channel");

  property p_irq_prio;
    // A pulse held over a frozen cycle is not a second pulse
    scan_end_irq && $past(clk_en) |-> scan_end_prio == 4'h5 && !$past(scan_end_irq);
  endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("scan end priority or width wrong");

  property p_no_other_irq;
    !(wcmp_a_irq || wcmp_b_irq || scan_end_b_irq);
  endproperty
  a_no_other_irq: assert property (p_no_other_irq) else $error("disabled interrupt raised");

  property p_tick;
    tick_event && $past(clk_en) |-> $past(tick_cnt_q) == ($clog2(TICK_CYC))'(TICK_CYC - 1) && tick_cnt_q == '0;
  endproperty
  a_tick: assert property (p_tick) else $error("tick at wrong count");

  property p_trip;
    !trip_s2_q |=> pwm_oe == 6'h00;
  endproperty
  a_trip: assert property (p_trip) else $error("outputs driven during overcurrent");

  property p_read_clear;
    (reg_rd && res_sel && !(st_q == mpa_pkg::MPA_S_WAIT && adc_done))
      |=> res_q[$past(res_idx)] == '0 && reg_rdata[31:12] == 20'h00000;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("result not cleared by read");

  property p_triangle;
    unf |=> cnt_q == '0 && !down_q;
  endproperty
  a_triangle: assert property (p_triangle) else $error("carrier did not turn at trough");

  c_full_scan: cover property (st_q == mpa_pkg::MPA_S_WAIT && adc_done && ch_q == 3'h4);
  c_trip:      cover property ($rose(tripped_q));
  c_tick:      cover property (tick_event);
endmodule : mpa_top

// [verification/mpa_stage_model.sv]
// Converter front end of the power stage sensing: answers each start with one done pulse.
// Assumes the block's clock; slow stretches every conversion so that a scan overruns a carrier period.
`timescale 1ns/1ps
module mpa_stage_model (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      slow,
  input  wire logic                      adc_start,
  output logic      [mpa_pkg::RES_W-1:0] adc_data,
  output logic                           adc_done
);
  logic [15:0] lfsr_q;
  int          wait_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lfsr_q   <= 16'hACE1;
      wait_q   <= 0;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end else begin
      lfsr_q   <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      adc_done <= 1'b0;
      // Outside the done pulse the lines toggle, so a stale result never looks valid
      adc_data <= ~adc_data;
      if (adc_start) begin
        wait_q <= slow ? 7 : 1 + int'(lfsr_q[0]);
      end else if (wait_q == 1) begin
        wait_q   <= 0;
        adc_done <= 1'b1;
        adc_data <= lfsr_q[11:0];
      end else if (wait_q > 1) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule : mpa_stage_model

// [verification/test_mpa_top.sv]
// Self-checking bench for the three-phase PWM with valley-synchronised sampling.
// Assumes mpa_stage_model as converter; small carrier and tick counts keep the run short.
`timescale 1ns/1ps
module test_mpa_top;
  localparam int TICK = 20;
  localparam int TOP  = 16;
  logic              clk, resetn, clk_en, reg_wr, reg_rd, trip_n, slow, adc_start, adc_done, tick_event;
  logic              scan_end_irq, scan_end_b_irq, wcmp_a_irq, wcmp_b_irq, h, l;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata, rnd;
  logic [5:0]        pwm_out, pwm_oe, hold;
  logic [2:0]        adc_ch, exp_ch;
  logic [3:0]        scan_end_prio;
  logic [11:0]       adc_data, res [5];
  logic [1:0]        prev [3];
  int                bad_count, total_checks, cyc, last0, last_t, dead, n_scan, wd, off_n [3];
  bit                mon_on, irq_due, skip_s, skip_t, en_q;
  mpa_top #(.TICK_CYC(TICK), .CARRIER_TOP(TOP)) i_dut (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .overcurrent_trip_input_n(trip_n), .adc_start(adc_start), .adc_ch(adc_ch), .adc_data(adc_data),
    .adc_done(adc_done), .scan_end_irq(scan_end_irq), .scan_end_prio(scan_end_prio),
    .scan_end_b_irq(scan_end_b_irq), .wcmp_a_irq(wcmp_a_irq), .wcmp_b_irq(wcmp_b_irq), .tick_event(tick_event));
  mpa_stage_model i_stage (
    .clk(clk), .resetn(resetn), .slow(slow), .adc_start(adc_start), .adc_data(adc_data), .adc_done(adc_done));
  always #10 clk = ~clk;
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e, input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk((reg_rdata & mask) === e, m);
  endtask : rd_chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // ****************
  // Port monitors
  // ****************
  // Frozen cycles only repeat stale outputs, so they are neither checked nor counted
  always @(negedge clk) begin
    if (mon_on && en_q) begin
      cyc++;
      chk(scan_end_prio === mpa_pkg::SCAN_END_PRIO, "scan end priority");
      chk({scan_end_b_irq, wcmp_a_irq, wcmp_b_irq} === 3'b000, "disabled interrupt raised");
      chk(scan_end_irq === irq_due, "scan end timing");
      irq_due = (adc_done === 1'b1) && (adc_ch === 3'h4);
      n_scan += irq_due;
      if (adc_done === 1'b1) res[adc_ch] = adc_data;
      if (adc_start === 1'b1) begin
        chk(adc_ch === exp_ch, "channel order in scan");
        exp_ch = 3'((exp_ch + 1) % 5);
        if (adc_ch === 3'h0) begin
          if (last0 > 0 && !skip_s) chk((cyc - last0) % (2 * TOP) == 0, "scan start off the valley");
          last0  = cyc;
          skip_s = 0;
        end
      end
      if (tick_event === 1'b1) begin
        if (last_t > 0 && !skip_t) chk(cyc - last_t == TICK, "tick interval");
        last_t = cyc;
        skip_t = 0;
      end
      for (int p = 0; p < 3; p++) begin
        h = pwm_out[2*p];
        l = pwm_out[2*p+1];
        chk(!(h && l), "both sides on");
        if ((h || l) && prev[p] != {h, l}) chk(prev[p] == 2'b00 && off_n[p] > dead, "dead time short");
        off_n[p] = (h || l) ? 0 : off_n[p] + 1;
        prev[p]  = {h, l};
      end
    end
  end
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    en_q <= clk_en;
    wd++;
    if (wd == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    {clk, resetn, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = '0;
    {clk_en, trip_n} = 2'b11;
    rnd = 32'h82fb;
    exp_ch = 3'h0;
    off_n = '{100, 100, 100};
    prev = '{2'b00, 2'b00, 2'b00};
    cycles(20);
    chk(pwm_oe === 6'h3F && pwm_out === 6'h00 && reg_rdata === 32'h0, "reset values");
    resetn <= 1'b1;
    mon_on = 1;
    rd_chk(mpa_pkg::A_DEAD, 32'hFFFFFFFF, 32'h0, "dead reset");
    rd_chk(mpa_pkg::A_CMP_W, 32'hFFFFFFFF, 32'h0, "compare reset");
    rd_chk(8'h3C, 32'hFFFFFFFF, 32'h0, "unmapped read");
    $display("test registers done");
    rnd  = lfsr_next(rnd);
    dead = 1 + rnd[1:0] % 3;
    wr(mpa_pkg::A_DEAD, 32'(dead));
    for (int p = 0; p < 3; p++) begin
      rnd = lfsr_next(rnd);
      wr(8'(mpa_pkg::A_CMP_U + 4 * p), 32'(2 + rnd[3:0] % 12));
    end
    wr(mpa_pkg::A_CTRL, 32'h1);
    cycles(400);
    // Slow conversions overrun the period, so the next valley must be dropped
    slow <= 1'b1;
    cycles(300);
    slow <= 1'b0;
    cycles(100);
    chk(n_scan > 8, "scans completed");
    $display("test pwm and scan done");
    for (int i = 0; i < 200 && scan_end_irq !== 1'b1; i++) @(posedge clk);
    chk(scan_end_irq === 1'b1, "no scan end before freeze");
    cycles(3);
    {skip_s, skip_t} = 2'b11;
    @(posedge clk);
    clk_en <= 1'b0;
    #1 hold = pwm_out;
    cycles(6);
    chk(pwm_out === hold, "outputs move while frozen");
    clk_en <= 1'b1;
    wr(mpa_pkg::A_CTRL, 32'h0);
    cycles(80);
    chk(pwm_out === 6'h00, "stopped timer drives sides");
    for (int i = 0; i < 5; i++) rd_chk(8'(mpa_pkg::A_RES0 + 4 * i), 32'hFFFFFFFF, {20'h0, res[i]}, "result");
    for (int i = 0; i < 5; i++) rd_chk(8'(mpa_pkg::A_RES0 + 4 * i), 32'hFFFFFFFF, 32'h0, "clear on read");
    $display("test results done");
    wr(mpa_pkg::A_CTRL, 32'h1);
    // The carrier restarts from zero, so the valley phase moves once
    skip_s = 1;
    rnd = lfsr_next(rnd);
    cycles(5 + rnd[4:0]);
    chk(pwm_oe === 6'h3F, "outputs enabled");
    trip_n <= 1'b0;
    cycles(4);
    #1 chk(pwm_oe === 6'h00, "trip not applied");
    rd_chk(mpa_pkg::A_STATUS, 32'h1, 32'h1, "trip status");
    wr(mpa_pkg::A_CTRL, 32'h3);
    cycles(2);
    chk(pwm_oe === 6'h00, "trip cleared while pin low");
    trip_n <= 1'b1;
    cycles(4);
    wr(mpa_pkg::A_CTRL, 32'h3);
    cycles(2);
    chk(pwm_oe === 6'h3F, "trip not cleared");
    $display("test trip done");
    tally_and_finish();
  end
endmodule : test_mpa_top
